//--- include/sfcp_regs.vh
// Purpose: constants for the serial memory command and protection block
// Assumes: plain Verilog-2005 includes
// Notes:   opcodes, status bit positions, protect ranges
`ifndef SFCP_REGS_VH
`define SFCP_REGS_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFCP_OP_LATCH_SET    8'h06
`define SFCP_OP_LATCH_CLEAR  8'h04
`define SFCP_OP_STATUS_READ  8'h05
`define SFCP_OP_STATUS_WRITE 8'h01
`define SFCP_OP_MEM_READ     8'h03
`define SFCP_OP_MEM_WRITE    8'h02

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SFCP_SR_PIN_GUARD    7
`define SFCP_SR_GUARD_HI     3
`define SFCP_SR_GUARD_LO     2
`define SFCP_SR_LATCH        1
`define SFCP_GUARD_RESET     2'h0
`define SFCP_PIN_GUARD_RESET 1'h0

// ----------------------------------------
// Address space and protected ranges
// ----------------------------------------
`define SFCP_ADDR_W          13
`define SFCP_ADDR_LAST       13'h1FFF
`define SFCP_PROT_QUARTER    13'h1800
`define SFCP_PROT_HALF       13'h1000
`define SFCP_PROT_ALL        13'h0000
`define SFCP_BIT_LAST        3'h7

// ----------------------------------------
// Power-up wait in ns, as a cycle count
// ----------------------------------------
`define SFCP_PU_WAIT_NS      250
`define SFCP_CLK_NS          25

`endif

//--- rtl/sfcp_sync.v
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input from outside the core_clk domain
// Notes:   output changes only once stages two and three agree
`timescale 1ns/10ps
module sfcp_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire core_clk,   // Core clock
  input  wire reset_n,    // Async reset, active low
  input  wire async_in,   // Raw pin level
  output reg  sync_out    // Filtered level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q     <= RESET_VAL;
      s2_q     <= RESET_VAL;
      s3_q     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end
endmodule // sfcp_sync

//--- rtl/sfcp_core.v
// Purpose: SPI-slave command interpreter and write protection of an 8K x 8 memory
// Assumes: SPI mode 0 or 3; pins sampled by core_clk well above link rate
// Notes:   reset_n stands for the power-on reset; block guard bits model nonvolatile cells
//
// Function
// - Write latch is clear after power-up.
// - Opcode 06h sets the write latch, shown in status bit 1.
// - Status write clears the write latch at the next select rise.
// - Select rising clears latch after latch-clear, status-write or memory-write.
// - Opcode 04h clears the write latch.
// - Status bits 0 and 4-6 read zero and are not writable.
// - Status layout: pin guard bit 7, block guards 3:2, latch bit 1.
// - Block guard bits are nonvolatile, factory value zero.
// - Guard code selects none, top quarter, top half or whole array.
// - Status write refused when latch clear, or when pin guard set and protect pin low.
// - Latch clear blocks all writes; set leaves only guarded blocks protected.
// - Opcode 05h shifts out the status byte.
// - Opcode 01h updates pin guard and block guards when allowed.
// - Memory write is 02h, two address bytes, 13-bit address, data MSB first.
// - Write address increments per byte, wraps 1FFFh to 0000h.
// - Each data byte is committed after its eighth bit.
// - Write burst stops at a guarded address and drops later bytes.
// - Opcode 03h plus address drives read data, serial input ignored.
// - Read bytes MSB first, address wraps; select rising tristates output.
// - Writes of any length accepted at full clock rate.
// - Unknown opcode ignored until next select fall, output tristated.
// - Input sampled on clock rise, output changed on clock fall.
`timescale 1ns/10ps
`include "sfcp_regs.vh"
module sfcp_core #(
  parameter ADDR_W = `SFCP_ADDR_W,
  parameter DEPTH  = 8192
) (
  input  wire core_clk,     // Core clock, 40 MHz
  input  wire reset_n,      // Power-on reset, active low
  input  wire sel_n_pin,    // Chip select, active low
  input  wire sck_pin,      // Serial clock from master
  input  wire si_pin,       // Serial data in
  input  wire prot_n_pin,   // Write protect pin, active low
  output reg  so_out,       // Serial data out
  output reg  so_oe,        // Serial out enable, high drives
  output reg  ready_q       // Power-up wait elapsed
);
  // ----------------------------------------
  // Power-up wait
  // ----------------------------------------
  localparam PU_CYC_RAW = (`SFCP_PU_WAIT_NS + `SFCP_CLK_NS - 1) / `SFCP_CLK_NS;
  localparam PU_CYC     = (PU_CYC_RAW < 1) ? 1 : PU_CYC_RAW;
  reg [15:0] pu_cnt_q;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pu_cnt_q <= 16'h0000;
      ready_q  <= 1'b0;
    end else if (pu_cnt_q != PU_CYC[15:0]) begin
      pu_cnt_q <= pu_cnt_q + 16'h0001;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire sel_n_s;
  wire sck_s;
  wire si_s;
  wire prot_n_s;

  sfcp_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .core_clk (core_clk), .reset_n (reset_n), .async_in (sel_n_pin), .sync_out (sel_n_s));
  sfcp_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .core_clk (core_clk), .reset_n (reset_n), .async_in (sck_pin), .sync_out (sck_s));
  sfcp_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .core_clk (core_clk), .reset_n (reset_n), .async_in (si_pin), .sync_out (si_s));
  sfcp_sync #(.RESET_VAL(1'b1)) u_sync_wp (
    .core_clk (core_clk), .reset_n (reset_n), .async_in (prot_n_pin), .sync_out (prot_n_s));

  reg  sel_n_q;
  reg  sck_q;
  wire sel_fall = sel_n_q & ~sel_n_s;
  wire sel_rise = ~sel_n_q & sel_n_s;
  wire sck_rise = ~sck_q & sck_s & ~sel_n_s;
  wire sck_fall = sck_q & ~sck_s & ~sel_n_s;

  // ----------------------------------------
  // Command states
  // ----------------------------------------
  localparam ST_IDLE   = 3'h0;
  localparam ST_OPCODE = 3'h1;
  localparam ST_ADDR   = 3'h2;
  localparam ST_WDATA  = 3'h3;
  localparam ST_RDATA  = 3'h4;
  localparam ST_SRWR   = 3'h5;
  localparam ST_SRRD   = 3'h6;
  localparam ST_IGNORE = 3'h7;

  reg [2:0]        state_q;
  reg [7:0]        opcode_q;
  reg [7:0]        shift_q;
  reg [2:0]        bit_q;
  reg              addr_hi_q;
  reg [ADDR_W-1:0] addr_q;
  reg [7:0]        tx_q;
  reg              halt_q;
  reg              latch_q;
  // Guard bits stand for nonvolatile cells: factory value only, no reset
  reg [1:0]        guard_q = `SFCP_GUARD_RESET;
  reg              pin_guard_q;
  reg              clr_on_rise_q;

  reg [7:0] mem [0:DEPTH-1];

  // Status byte: unused bits tied low
  wire [7:0] status_byte = {pin_guard_q, 3'h0, guard_q, latch_q, 1'b0};

  wire [7:0] rx_byte = {shift_q[6:0], si_s};
  wire       byte_end = sck_rise & (bit_q == `SFCP_BIT_LAST);

  // Guarded address test
  function guarded;
    input [1:0]        code;
    input [ADDR_W-1:0] a;
    begin
      case (code)
        2'h1:    guarded = (a >= `SFCP_PROT_QUARTER);
        2'h2:    guarded = (a >= `SFCP_PROT_HALF);
        2'h3:    guarded = (a >= `SFCP_PROT_ALL);
        default: guarded = 1'b0;
      endcase
    end
  endfunction

  wire addr_guarded = guarded(guard_q, addr_q);
  wire sr_locked    = pin_guard_q & ~prot_n_s;

  // ----------------------------------------
  // Memory commit
  // ----------------------------------------
  wire mem_we = (state_q == ST_WDATA) & byte_end & latch_q & ~halt_q & ~addr_guarded;

  always @(posedge core_clk) begin
    if (mem_we) begin
      mem[addr_q] <= rx_byte;
    end
  end

  // ----------------------------------------
  // Block guard cells
  // ----------------------------------------
  // Kept out of the reset process so a power cycle leaves the guard code intact
  wire guard_we = (state_q == ST_SRWR) & byte_end & latch_q & ~sr_locked;

  always @(posedge core_clk) begin
    if (guard_we) begin
      guard_q <= rx_byte[`SFCP_SR_GUARD_HI:`SFCP_SR_GUARD_LO];
    end
  end

  // ----------------------------------------
  // Command interpreter
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_n_q       <= 1'b1;
      sck_q         <= 1'b0;
      state_q       <= ST_IDLE;
      opcode_q      <= 8'h00;
      shift_q       <= 8'h00;
      bit_q         <= 3'h0;
      addr_hi_q     <= 1'b0;
      addr_q        <= {ADDR_W{1'b0}};
      tx_q          <= 8'h00;
      halt_q        <= 1'b0;
      latch_q       <= 1'b0;
      pin_guard_q   <= `SFCP_PIN_GUARD_RESET;
      clr_on_rise_q <= 1'b0;
      so_out        <= 1'b0;
      so_oe         <= 1'b0;
    end else begin
      sel_n_q <= sel_n_s;
      sck_q   <= sck_s;
      if (sel_rise) begin
        state_q <= ST_IDLE;
        so_oe   <= 1'b0;
        if (clr_on_rise_q) begin
          latch_q <= 1'b0;
        end
        clr_on_rise_q <= 1'b0;
      end else if (sel_fall) begin
        state_q <= ready_q ? ST_OPCODE : ST_IGNORE;
        bit_q   <= 3'h0;
        halt_q  <= 1'b0;
        so_oe   <= 1'b0;
      end else begin
        if (sck_rise) begin
          shift_q <= rx_byte;
          bit_q   <= bit_q + 3'h1;
        end
        case (state_q)
          ST_OPCODE: begin
            if (byte_end) begin
              opcode_q  <= rx_byte;
              addr_hi_q <= 1'b1;
              case (rx_byte)
                `SFCP_OP_LATCH_SET:    begin latch_q <= 1'b1; state_q <= ST_IGNORE; end
                `SFCP_OP_LATCH_CLEAR:  begin
                  latch_q       <= 1'b0;
                  clr_on_rise_q <= 1'b1;
                  state_q       <= ST_IGNORE;
                end
                `SFCP_OP_STATUS_READ:  begin tx_q <= status_byte; state_q <= ST_SRRD; end
                `SFCP_OP_STATUS_WRITE: state_q <= ST_SRWR;
                `SFCP_OP_MEM_READ:     state_q <= ST_ADDR;
                `SFCP_OP_MEM_WRITE:    state_q <= ST_ADDR;
                default:               state_q <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            if (byte_end) begin
              addr_hi_q <= 1'b0;
              if (addr_hi_q) begin
                addr_q[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
              end else begin
                addr_q[7:0] <= rx_byte;
                if (opcode_q == `SFCP_OP_MEM_READ) begin
                  tx_q    <= mem[{addr_q[ADDR_W-1:8], rx_byte}];
                  state_q <= ST_RDATA;
                end else begin
                  clr_on_rise_q <= 1'b1;
                  state_q       <= ST_WDATA;
                end
              end
            end
          end
          ST_WDATA: begin
            if (byte_end) begin
              if (!latch_q || halt_q || addr_guarded) begin
                halt_q <= latch_q;
              end else begin
                addr_q <= addr_q + 1'b1;
              end
            end
          end
          ST_SRWR: begin
            if (byte_end) begin
              clr_on_rise_q <= 1'b1;
              if (latch_q && !sr_locked) begin
                pin_guard_q <= rx_byte[`SFCP_SR_PIN_GUARD];
              end
              state_q <= ST_IGNORE;
            end
          end
          ST_RDATA, ST_SRRD: begin
            if (sck_fall) begin
              so_oe  <= 1'b1;
              so_out <= tx_q[7];
              tx_q   <= {tx_q[6:0], 1'b0};
            end else if (byte_end) begin
              if (state_q == ST_RDATA) begin
                addr_q <= addr_q + 1'b1;
                tx_q   <= mem[addr_q + 1'b1];
              end else begin
                tx_q <= status_byte;
              end
            end
          end
          default: begin
            so_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // sfcp_core

//--- verif/sfcp_core_asserts.sv
// Purpose: port assertions for the serial memory command block
// Assumes: pins come from outside the core clock domain
// Notes:   opcode is tracked from the raw pins, so figures allow for sync delay
`timescale 1ns/10ps
module sfcp_core_asserts (
  input logic core_clk,    // Core clock
  input logic reset_n,     // Reset, active low
  input logic sel_n_pin,   // Select, active low
  input logic sck_pin,     // Serial clock
  input logic si_pin,      // Serial in
  input logic prot_n_pin,  // Protect pin, active low
  input logic so_out,      // Serial out
  input logic so_oe,       // Serial out enable
  input logic ready_q      // Wait elapsed
);
  logic [4:0] n_q;
  logic [7:0] sh_q;
  logic [7:0] op_q;
  // Rise count saturates so long bursts never wrap back below 8
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      n_q  <= 5'h00;
      sh_q <= 8'h00;
      op_q <= 8'h00;
    end else if (sel_n_pin) begin
      n_q <= 5'h00;
    end else if ($rose(sck_pin)) begin
      if (n_q != 5'h1F) n_q <= n_q + 5'h01;
      if (n_q == 5'h07) op_q <= {sh_q[6:0], si_pin};
      sh_q <= {sh_q[6:0], si_pin};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_ready_wait; $rose(reset_n) |-> !ready_q [*8] ##[1:8] ready_q; endproperty
  property p_ready_hold; ready_q |=> ready_q; endproperty
  property p_oe_early; !ready_q |-> !so_oe; endproperty
  property p_oe_idle; sel_n_pin [*8] |-> !so_oe; endproperty
  property p_oe_cause;
    $rose(so_oe) |-> (op_q == 8'h05 && n_q >= 5'h08) || (op_q == 8'h03 && n_q >= 5'h18);
  endproperty
  property p_bad_op;
    !sel_n_pin && n_q >= 5'h08 && (op_q > 8'h06 || op_q == 8'h00) |-> !so_oe;
  endproperty
  property p_so_hold; $fell(sck_pin) |=> $stable(so_out) [*2]; endproperty
  property p_oe_hold; so_oe && !sel_n_pin |=> so_oe; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late or early");
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  a_oe_early: assert property (p_oe_early) else $error("output before ready");
  a_oe_idle: assert property (p_oe_idle) else $error("output while idle");
  a_oe_cause: assert property (p_oe_cause) else $error("output without read");
  a_bad_op: assert property (p_bad_op) else $error("output on bad opcode");
  a_so_hold: assert property (p_so_hold) else $error("output moved at clock fall");
  a_oe_hold: assert property (p_oe_hold) else $error("output dropped in frame");
  c_stat: cover property ($rose(so_oe) && op_q == 8'h05);
  c_read: cover property ($rose(so_oe) && op_q == 8'h03);
  c_bad: cover property (n_q == 5'h08 && op_q == 8'hFF);
endmodule // sfcp_core_asserts
bind sfcp_core sfcp_core_asserts u_chk (.core_clk, .reset_n, .sel_n_pin, .sck_pin,
  .si_pin, .prot_n_pin, .so_out, .so_oe, .ready_q);

//--- verif/sfcp_master.sv
// Purpose: SPI master model for the serial memory block
// Assumes: mode 0 or 3 by cpol, 200 ns serial clock
// Notes:   read data sampled late in the high phase to allow sync delay
`timescale 1ns/10ps
module sfcp_master (
  output reg  sel_n,   // Select, active low
  output reg  sck,     // Serial clock
  output reg  si,      // Serial data to device
  input  wire so_out,  // Serial data from device
  input  wire so_oe    // Device drives serial out
);
  reg       cpol;
  reg [7:0] d;
  initial begin
    {sel_n, sck, si, cpol} = 4'h8;
  end
  // Released line reads inverted so a stale level never passes
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      sck = 1'b0;
      si = tx[i];
      #100 sck = 1'b1;
      #99 rx[i] = so_oe ? so_out : ~so_out;
      #1;
    end
  endtask
  task go(input [7:0] op);
    sck = cpol;
    #50 sel_n = 1'b0;
    #100 xfer(op, d);
  endtask
  task stop;
    sck = cpol;
    #100 sel_n = 1'b1;
    #300;
  endtask
endmodule // sfcp_master

//--- verif/tb_sfcp_core.sv
// Purpose: self-checking bench for the serial memory command block
// Assumes: 40 MHz core clock, 200 ns serial clock
// Notes:   status writes run from a row table, memory cases by hand
`timescale 1ns/10ps
module tb_sfcp_core;
  reg         core_clk;
  reg         reset_n;
  reg         prot_n_pin;
  wire        sel_n_pin, sck_pin, si_pin, so_out, so_oe, ready_q;
  reg  [7:0]  s;
  integer     i, k, num_errors, n_compared, cyc;
  // Rows: latch set first, protect pin, byte written, status expected
  localparam logic [17:0] rows [0:5] = '{18'h3FF8C, 18'h2008C, 18'h30200,
    18'h20404, 18'h10804, 18'h30808};
  sfcp_core dut (.core_clk, .reset_n, .sel_n_pin, .sck_pin, .si_pin, .prot_n_pin,
    .so_out, .so_oe, .ready_q);
  sfcp_master m (.sel_n(sel_n_pin), .sck(sck_pin), .si(si_pin), .so_out, .so_oe);
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  task wrap_up;
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task op1(input [7:0] o);
    m.go(o);
    m.stop;
  endtask
  task status_read_cmd(input [7:0] exp);
    m.go(8'h05);
    m.xfer(8'hA5, s);
    m.stop;
    chk(s, exp);
  endtask
  // Burst of n bytes from v, top byte first; reads compare each byte
  task acc(input [7:0] o, input [15:0] a, input [23:0] v, input integer n);
    m.go(o);
    m.xfer(a[15:8], s);
    m.xfer(a[7:0], s);
    for (k = 0; k < n; k = k + 1) begin
      m.xfer(v[23-8*k -: 8], s);
      if (o == 8'h03) chk(s, v[23-8*k -: 8]);
    end
    m.stop;
  endtask
  initial begin
    {core_clk, reset_n, prot_n_pin} = 3'h1;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    repeat (30) @(negedge core_clk);
    status_read_cmd(8'h00);
    op1(8'h06);
    status_read_cmd(8'h02);
    acc(8'h02, 16'hFFFF, 24'h445500, 2);
    op1(8'h06);
    acc(8'h02, 16'h0FFF, 24'h5AC300, 2);
    for (i = 0; i < 6; i = i + 1) begin
      @(negedge core_clk) prot_n_pin = rows[i][16];
      if (rows[i][17]) op1(8'h06);
      m.go(8'h01);
      m.xfer(rows[i][15:8], s);
      m.stop;
      status_read_cmd(rows[i][7:0]);
    end
    op1(8'h06);
    status_read_cmd(8'h0A);
    op1(8'h04);
    status_read_cmd(8'h08);
    op1(8'h06);
    acc(8'h02, 16'hEFFE, 24'h112233, 3);
    status_read_cmd(8'h08);
    acc(8'h02, 16'h0FFE, 24'h770000, 1);
    acc(8'h03, 16'hEFFE, 24'h1122C3, 3);
    chk({7'h00, so_oe}, 8'h00);
    m.go(8'hFF);
    m.xfer(8'h06, s);
    chk({7'h00, so_oe}, 8'h00);
    m.stop;
    status_read_cmd(8'h08);
    op1(8'h06);
    @(negedge core_clk) reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (30) @(negedge core_clk);
    status_read_cmd(8'h08);
    m.cpol = 1'b1;
    acc(8'h03, 16'h1FFF, 24'h445500, 2);
    wrap_up;
  end
endmodule // tb_sfcp_core
